// ---- rtl/bert_pkg.sv ----
// constants and types for the prbs bit-error-rate test engine
// Functional notes
// - checker selectable: pattern checker or serial bit comparator
// - comparator mode still sends prbs; comparator finds the errors
// - bypass mode: start begins comparator bit and error counting
// - count tested bits since last checker reset
// - count mismatched bits since last checker reset
// - error ratio is error count over tested-bit count
// - inject request inverts exactly one output bit
// - preamble sent for programmable cycle count before pattern
// - preamble word programmable, used only in preamble operation
// - limits checked after programmed bits; two consecutive checks in violation end the test
// - ratio below lower threshold ends the test
// - ratio above upper threshold ends the test
// - test stops when tested bits reach programmable maximum
// - serial loopback routes transmit data back to receiver
// - word alignment aligns incoming data to a programmed word
// - frequency counter measures data rate on management clock timebase
// - reference clock frequency calculated from measured data rate
// - pattern select: prbs 7/15/23/31, low, high frequency, bypass
// - without preamble the pattern starts immediately on start
// - checker reports lock onto incoming pattern
package bert_pkg;
  localparam int DW = 32;
  localparam int AW = 8;
  // register byte offsets
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_CFG = 8'h04;
  localparam logic [7:0] A_PRE = 8'h08;
  localparam logic [7:0] A_BEATS = 8'h0C;
  localparam logic [7:0] A_MAXB = 8'h10;
  localparam logic [7:0] A_LSTART = 8'h14;
  localparam logic [7:0] A_BLO = 8'h18;
  localparam logic [7:0] A_BHI = 8'h1C;
  localparam logic [7:0] A_ALIGN = 8'h20;
  localparam logic [7:0] A_MULT = 8'h24;
  localparam logic [7:0] A_STAT = 8'h28;
  localparam logic [7:0] A_BITS = 8'h2C;
  localparam logic [7:0] A_ERRS = 8'h30;
  localparam logic [7:0] A_RATIO = 8'h34;
  localparam logic [7:0] A_RATE = 8'h38;
  localparam logic [7:0] A_REFCLK = 8'h3C;
  // command bits
  localparam int C_START = 0;
  localparam int C_STOP = 1;
  localparam int C_CLR = 2;
  localparam int C_INJ = 3;
  // pattern codes
  localparam logic [2:0] PAT_P7 = 3'h0;
  localparam logic [2:0] PAT_P15 = 3'h1;
  localparam logic [2:0] PAT_P23 = 3'h2;
  localparam logic [2:0] PAT_P31 = 3'h3;
  localparam logic [2:0] PAT_LF = 3'h4;
  localparam logic [2:0] PAT_HF = 3'h5;
  localparam logic [2:0] PAT_BYP = 3'h6;
  localparam logic [31:0] LF_WORD = 32'hFF00FF00;
  localparam logic [31:0] HF_WORD = 32'hAAAAAAAA;
  localparam logic [31:0] SEED = 32'hFFFFFFFF;
  localparam logic [31:0] BITS_PER_WORD = 32'h00000020;
  localparam int RATIO_SHIFT = 24;
  localparam logic [2:0] LOCK_WORDS = 3'h4;
  localparam logic [1:0] LIMIT_HITS = 2'h2;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [31:0] ZERO_RST = 32'h00000000;
  localparam logic [31:0] MULT_RST = 32'h00000001;
  // frequency counter timebase
  localparam int CLK_PERIOD_NS = 100;
  localparam int RATE_WINDOW_NS = 1000000;
  localparam int RATE_WINDOW_CYC = RATE_WINDOW_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic align_en;
    logic loopback;
    logic limit_en;
    logic preamble_en;
    logic comparator;
    logic [2:0] pattern;
  } cfg_type;

  typedef struct packed {
    logic maxed;
    logic fail_high;
    logic pass_low;
    logic done;
    logic locked;
    logic checking;
    logic sending;
  } stat_type;

  typedef enum {G_IDLE, G_PRE, G_RUN} gen_state_type;
endpackage

// ---- rtl/prbs_ber_test_engine.sv ----
// prbs generator, checker, counters, limits and rate meter behind apb
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module prbs_ber_test_engine #(
  parameter int RATE_WINDOW = bert_pkg::RATE_WINDOW_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // apb slave
  input wire logic [bert_pkg::AW-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  // transceiver link
  output logic [31:0] tx_data_out,
  input wire logic [31:0] rx_data_in,
  input wire logic rx_valid_in,
  input wire logic [31:0] user_data_in,
  // status
  output logic checking_out,
  output logic locked_out,
  output logic done_out
);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] prbs_next(input logic [2:0] pat, input logic [31:0] s);
    logic [31:0] r;
    logic b;
    r = s;
    for (int i = 0; i < 32; i++) begin
      case (pat)
        bert_pkg::PAT_P7: b = r[6] ^ r[5];
        bert_pkg::PAT_P15: b = r[14] ^ r[13];
        bert_pkg::PAT_P23: b = r[22] ^ r[17];
        default: b = r[30] ^ r[27];
      endcase
      r = {r[30:0], b};
    end
    return r;
  endfunction

  function automatic logic [31:0] pattern_word(input logic [2:0] pat, input logic [31:0] s);
    logic [31:0] w;
    case (pat)
      bert_pkg::PAT_LF: w = bert_pkg::LF_WORD;
      bert_pkg::PAT_HF: w = bert_pkg::HF_WORD;
      default: w = prbs_next(pat, s);
    endcase
    return w;
  endfunction

  function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[32] ? 32'hFFFFFFFF : s[31:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register file
  bert_pkg::cfg_type cfg_reg, cfg_next;
  logic [31:0] pre_reg, pre_next, beats_reg, beats_next, maxb_reg, maxb_next;
  logic [31:0] lstart_reg, lstart_next, blo_reg, blo_next, bhi_reg, bhi_next;
  logic [31:0] align_reg, align_next, mult_reg, mult_next, prdata_reg, prdata_next;
  logic [3:0] cmd;
  logic wr, rd_setup, mapped;
  bert_pkg::stat_type stat;

  // datapath state
  bert_pkg::gen_state_type gst_reg, gst_next;
  logic [31:0] beat_reg, beat_next, gen_reg, gen_next, tx_reg, tx_next, txd_reg, txd_next;
  logic inj_reg, inj_next, new_reg, new_next, flip_reg, flip_next;
  logic [31:0] prev_reg, prev_next, cur_reg, cur_next, last_reg, last_next;
  logic [4:0] shift_reg, shift_next;
  logic aligned_reg, aligned_next, locked_reg, locked_next, chk_reg, chk_next;
  logic [2:0] lock_reg, lock_next;
  logic [31:0] bits_reg, bits_next, errs_reg, errs_next, ratio_reg, ratio_next;
  logic [1:0] hlo_reg, hlo_next, hhi_reg, hhi_next;
  logic done_reg, done_next, flo_reg, flo_next, fhi_reg, fhi_next, max_reg, max_next;
  logic [31:0] win_reg, win_next, acc_reg, acc_next, rate_reg, rate_next;
  logic [31:0] ref_reg, ref_next;

  assign wr = psel_in & penable_in & pwrite_in;
  assign rd_setup = psel_in & ~penable_in & ~pwrite_in;
  assign cmd = (wr && paddr_in == bert_pkg::A_CMD) ? pwdata_in[3:0] : 4'h0;
  assign pready_out = psel_in & penable_in;
  assign pslverr_out = pready_out & ~mapped;
  assign prdata_out = prdata_reg;
  assign stat = '{max_reg, fhi_reg, flo_reg, done_reg, locked_reg, chk_reg, gst_reg != bert_pkg::G_IDLE};

  always_comb begin
    mapped = (paddr_in[1:0] == 2'h0) && (paddr_in <= bert_pkg::A_REFCLK);
    cfg_next = cfg_reg;
    pre_next = pre_reg;
    beats_next = beats_reg;
    maxb_next = maxb_reg;
    lstart_next = lstart_reg;
    blo_next = blo_reg;
    bhi_next = bhi_reg;
    align_next = align_reg;
    mult_next = mult_reg;
    prdata_next = prdata_reg;
    if (wr) begin
      case (paddr_in)
        bert_pkg::A_CFG: cfg_next = pwdata_in[7:0];
        bert_pkg::A_PRE: pre_next = pwdata_in;
        bert_pkg::A_BEATS: beats_next = pwdata_in;
        bert_pkg::A_MAXB: maxb_next = pwdata_in;
        bert_pkg::A_LSTART: lstart_next = pwdata_in;
        bert_pkg::A_BLO: blo_next = pwdata_in;
        bert_pkg::A_BHI: bhi_next = pwdata_in;
        bert_pkg::A_ALIGN: align_next = pwdata_in;
        bert_pkg::A_MULT: mult_next = pwdata_in;
        default: ;
      endcase
    end
    if (rd_setup) begin
      case (paddr_in)
        bert_pkg::A_CFG: prdata_next = {24'h000000, cfg_reg};
        bert_pkg::A_PRE: prdata_next = pre_reg;
        bert_pkg::A_BEATS: prdata_next = beats_reg;
        bert_pkg::A_MAXB: prdata_next = maxb_reg;
        bert_pkg::A_LSTART: prdata_next = lstart_reg;
        bert_pkg::A_BLO: prdata_next = blo_reg;
        bert_pkg::A_BHI: prdata_next = bhi_reg;
        bert_pkg::A_ALIGN: prdata_next = align_reg;
        bert_pkg::A_MULT: prdata_next = mult_reg;
        bert_pkg::A_STAT: prdata_next = {25'h0000000, stat};
        bert_pkg::A_BITS: prdata_next = bits_reg;
        bert_pkg::A_ERRS: prdata_next = errs_reg;
        bert_pkg::A_RATIO: prdata_next = ratio_reg;
        bert_pkg::A_RATE: prdata_next = rate_reg;
        bert_pkg::A_REFCLK: prdata_next = ref_reg;
        default: prdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cfg_reg <= bert_pkg::CFG_RST;
      pre_reg <= bert_pkg::ZERO_RST;
      beats_reg <= bert_pkg::ZERO_RST;
      maxb_reg <= bert_pkg::ZERO_RST;
      lstart_reg <= bert_pkg::ZERO_RST;
      blo_reg <= bert_pkg::ZERO_RST;
      bhi_reg <= bert_pkg::ZERO_RST;
      align_reg <= bert_pkg::ZERO_RST;
      mult_reg <= bert_pkg::MULT_RST;
      prdata_reg <= bert_pkg::ZERO_RST;
    end else begin
      cfg_reg <= cfg_next;
      pre_reg <= pre_next;
      beats_reg <= beats_next;
      maxb_reg <= maxb_next;
      lstart_reg <= lstart_next;
      blo_reg <= blo_next;
      bhi_reg <= bhi_next;
      align_reg <= align_next;
      mult_reg <= mult_next;
      prdata_reg <= prdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive word, alignment and error count
  logic [31:0] rx_word, data, expect_w, diff;
  logic [63:0] dword;
  logic [5:0] pop;
  logic [4:0] found_k;
  logic found, count_en, below, above;
  logic [63:0] err_scaled, lo_prod, hi_prod;
  logic [31:0] word_errs;

  assign rx_word = cfg_reg.loopback ? tx_reg : rx_data_in;
  assign dword = {cur_reg, prev_reg};
  assign data = cfg_reg.align_en ? dword[shift_reg +: 32] : cur_reg;
  assign tx_data_out = tx_reg;
  assign checking_out = chk_reg;
  assign locked_out = locked_reg;
  assign done_out = done_reg;

  always_comb begin
    found = 1'b0;
    found_k = 5'h00;
    for (int k = 31; k >= 0; k--) begin
      if (dword[k +: 32] == align_reg) begin
        found = 1'b1;
        found_k = 5'(k);
      end
    end
    // comparator checks against the word sent one cycle earlier
    if (cfg_reg.comparator || cfg_reg.pattern == bert_pkg::PAT_BYP)
      expect_w = txd_reg;
    else if (cfg_reg.pattern == bert_pkg::PAT_LF || cfg_reg.pattern == bert_pkg::PAT_HF)
      expect_w = last_reg;
    else
      expect_w = prbs_next(cfg_reg.pattern, last_reg);
    diff = data ^ expect_w;
    pop = 6'h00;
    for (int i = 0; i < 32; i++) pop = pop + 6'(diff[i]);
    word_errs = {26'h0000000, pop};
    err_scaled = {errs_reg, 32'h00000000} >> (32 - bert_pkg::RATIO_SHIFT);
    lo_prod = 64'(blo_reg) * 64'(bits_reg);
    hi_prod = 64'(bhi_reg) * 64'(bits_reg);
    below = err_scaled < lo_prod;
    above = err_scaled > hi_prod;
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    gst_next = gst_reg;
    beat_next = beat_reg;
    gen_next = gen_reg;
    tx_next = tx_reg;
    txd_next = tx_reg ^ 32'(flip_reg);
    flip_next = 1'b0;
    inj_next = inj_reg | cmd[bert_pkg::C_INJ];
    new_next = cfg_reg.loopback | rx_valid_in;
    prev_next = prev_reg;
    cur_next = cur_reg;
    last_next = last_reg;
    shift_next = shift_reg;
    aligned_next = aligned_reg;
    lock_next = lock_reg;
    locked_next = locked_reg;
    chk_next = chk_reg;
    bits_next = bits_reg;
    errs_next = errs_reg;
    hlo_next = hlo_reg;
    hhi_next = hhi_reg;
    done_next = done_reg;
    flo_next = flo_reg;
    fhi_next = fhi_reg;
    max_next = max_reg;
    win_next = win_reg + 32'h00000001;
    acc_next = acc_reg;
    rate_next = rate_reg;
    ref_next = ref_reg;
    count_en = 1'b0;
    // generator
    case (gst_reg)
      bert_pkg::G_IDLE: tx_next = bert_pkg::ZERO_RST;
      bert_pkg::G_PRE: begin
        tx_next = pre_reg;
        beat_next = beat_reg + 32'h00000001;
        if (beat_next >= beats_reg) gst_next = bert_pkg::G_RUN;
      end
      bert_pkg::G_RUN: begin
        if (cfg_reg.pattern == bert_pkg::PAT_BYP) begin
          tx_next = user_data_in;
        end else begin
          tx_next = pattern_word(cfg_reg.pattern, gen_reg);
          gen_next = tx_next;
        end
        if (inj_reg) begin
          tx_next[0] = ~tx_next[0];
          flip_next = 1'b1;
          inj_next = cmd[bert_pkg::C_INJ];
        end
      end
      default: gst_next = bert_pkg::G_IDLE;
    endcase
    // receive capture and alignment search
    if (new_next) begin
      prev_next = cur_reg;
      cur_next = rx_word;
    end
    if (!cfg_reg.align_en) aligned_next = 1'b0;
    else if (new_reg && !aligned_reg && found) begin
      shift_next = found_k;
      aligned_next = 1'b1;
    end
    // checker lock and counting
    if (new_reg) begin
      last_next = data;
      if (cfg_reg.comparator || cfg_reg.pattern == bert_pkg::PAT_BYP) begin
        locked_next = 1'b1;
      end else if (!locked_reg) begin
        lock_next = (diff == 32'h00000000) ? lock_reg + 3'h1 : 3'h0;
        locked_next = lock_next >= bert_pkg::LOCK_WORDS;
      end
      count_en = chk_reg && (locked_reg || cfg_reg.comparator
                 || cfg_reg.pattern == bert_pkg::PAT_BYP);
    end
    if (count_en) begin
      bits_next = sat_add(bits_reg, bert_pkg::BITS_PER_WORD);
      errs_next = sat_add(errs_reg, word_errs);
      if (cfg_reg.limit_en && bits_reg >= lstart_reg) begin
        hlo_next = below ? hlo_reg + 2'h1 : 2'h0;
        hhi_next = above ? hhi_reg + 2'h1 : 2'h0;
      end
    end
    if (chk_reg && hlo_reg == bert_pkg::LIMIT_HITS) flo_next = 1'b1;
    if (chk_reg && hhi_reg == bert_pkg::LIMIT_HITS) fhi_next = 1'b1;
    if (chk_reg && maxb_reg != 32'h00000000 && bits_next >= maxb_reg)
      max_next = 1'b1;
    if (chk_reg && (flo_next || fhi_next || max_next)) begin
      done_next = 1'b1;
      chk_next = 1'b0;
      gst_next = bert_pkg::G_IDLE;
    end
    // commands: stop, start, counter clear
    if (cmd[bert_pkg::C_STOP]) begin
      chk_next = 1'b0;
      gst_next = bert_pkg::G_IDLE;
    end
    if (cmd[bert_pkg::C_START]) begin
      chk_next = 1'b1;
      done_next = 1'b0;
      flo_next = 1'b0;
      fhi_next = 1'b0;
      max_next = 1'b0;
      hlo_next = 2'h0;
      hhi_next = 2'h0;
      beat_next = bert_pkg::ZERO_RST;
      gen_next = bert_pkg::SEED;
      // no preamble (or zero beats): pattern goes out on the next word
      gst_next = (cfg_reg.preamble_en && beats_reg != 32'h00000000) ?
                 bert_pkg::G_PRE : bert_pkg::G_RUN;
    end
    if (cmd[bert_pkg::C_CLR] || cmd[bert_pkg::C_START]) begin
      bits_next = bert_pkg::ZERO_RST;
      errs_next = bert_pkg::ZERO_RST;
      lock_next = 3'h0;
      locked_next = 1'b0;
      hlo_next = 2'h0;
      hhi_next = 2'h0;
    end
    // ratio in 8.24 fixed point; a wide divide, fine at this clock rate
    ratio_next = (bits_reg == 32'h00000000) ? 32'h00000000 :
                 32'(err_scaled / 64'(bits_reg));
    // frequency counter over a fixed window of management clocks
    if (new_reg) acc_next = sat_add(acc_reg, bert_pkg::BITS_PER_WORD);
    if (win_reg >= 32'(RATE_WINDOW - 1)) begin
      win_next = bert_pkg::ZERO_RST;
      rate_next = acc_next;
      ref_next = (mult_reg == 32'h00000000) ? 32'h00000000 : acc_next / mult_reg;
      acc_next = bert_pkg::ZERO_RST;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      gst_reg <= bert_pkg::G_IDLE;
      beat_reg <= bert_pkg::ZERO_RST;
      gen_reg <= bert_pkg::SEED;
      tx_reg <= bert_pkg::ZERO_RST;
      txd_reg <= bert_pkg::ZERO_RST;
      inj_reg <= 1'b0;
      flip_reg <= 1'b0;
      new_reg <= 1'b0;
      prev_reg <= bert_pkg::ZERO_RST;
      cur_reg <= bert_pkg::ZERO_RST;
      last_reg <= bert_pkg::ZERO_RST;
      shift_reg <= 5'h00;
      aligned_reg <= 1'b0;
      lock_reg <= 3'h0;
      locked_reg <= 1'b0;
      chk_reg <= 1'b0;
      bits_reg <= bert_pkg::ZERO_RST;
      errs_reg <= bert_pkg::ZERO_RST;
      ratio_reg <= bert_pkg::ZERO_RST;
      hlo_reg <= 2'h0;
      hhi_reg <= 2'h0;
      done_reg <= 1'b0;
      flo_reg <= 1'b0;
      fhi_reg <= 1'b0;
      max_reg <= 1'b0;
      win_reg <= bert_pkg::ZERO_RST;
      acc_reg <= bert_pkg::ZERO_RST;
      rate_reg <= bert_pkg::ZERO_RST;
      ref_reg <= bert_pkg::ZERO_RST;
    end else begin
      gst_reg <= gst_next;
      beat_reg <= beat_next;
      gen_reg <= gen_next;
      tx_reg <= tx_next;
      txd_reg <= txd_next;
      inj_reg <= inj_next;
      flip_reg <= flip_next;
      new_reg <= new_next;
      prev_reg <= prev_next;
      cur_reg <= cur_next;
      last_reg <= last_next;
      shift_reg <= shift_next;
      aligned_reg <= aligned_next;
      lock_reg <= lock_next;
      locked_reg <= locked_next;
      chk_reg <= chk_next;
      bits_reg <= bits_next;
      errs_reg <= errs_next;
      ratio_reg <= ratio_next;
      hlo_reg <= hlo_next;
      hhi_reg <= hhi_next;
      done_reg <= done_next;
      flo_reg <= flo_next;
      fhi_reg <= fhi_next;
      max_reg <= max_next;
      win_reg <= win_next;
      acc_reg <= acc_next;
      rate_reg <= rate_next;
      ref_reg <= ref_next;
    end
  end
endmodule // prbs_ber_test_engine
`default_nettype wire

// ---- verif/bert_asserts.sv ----
// port assertions for the prbs ber test engine
`timescale 1ns/1ns
`default_nettype none
module bert_asserts (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // apb requests
  input wire logic [bert_pkg::AW-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  // link and status
  input wire logic [31:0] tx_data_out,
  input wire logic [31:0] user_data_in,
  input wire logic checking_out,
  input wire logic locked_out,
  input wire logic done_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////////////////////////
  // shadow of written config, only what the tx checks need
  bert_pkg::cfg_type cfg_reg, cfg_next;
  logic [31:0] pre_reg, pre_next;
  logic beats_reg, beats_next;
  logic wr, cmd, go, fixed;
  assign wr = psel_in & penable_in & pwrite_in;
  assign cmd = wr && paddr_in == bert_pkg::A_CMD;
  assign go = cmd && pwdata_in[bert_pkg::C_START];
  assign fixed = !cfg_reg.preamble_en && cfg_reg.pattern inside {bert_pkg::PAT_LF, bert_pkg::PAT_HF};
  always_comb begin
    cfg_next = cfg_reg;
    pre_next = pre_reg;
    beats_next = beats_reg;
    if (wr && paddr_in == bert_pkg::A_CFG) cfg_next = bert_pkg::cfg_type'(pwdata_in[7:0]);
    if (wr && paddr_in == bert_pkg::A_PRE) pre_next = pwdata_in;
    if (wr && paddr_in == bert_pkg::A_BEATS) beats_next = pwdata_in != 32'h0;
  end
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cfg_reg <= bert_pkg::cfg_type'(bert_pkg::CFG_RST);
      pre_reg <= bert_pkg::ZERO_RST;
      beats_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      pre_reg <= pre_next;
      beats_reg <= beats_next;
    end
  end
  ////////////////////////////////////////////////////////////
  property p_start_checks;
    go |-> ##[1:2] checking_out;
  endproperty
  a_start_checks: assert property (p_start_checks)
    else $error("start did not raise checking");
  property p_check_cause;
    $rose(checking_out) |-> $past(go) || $past(go, 2);
  endproperty
  a_check_cause: assert property (p_check_cause)
    else $error("checking rose without start");
  property p_stop_quiet;
    cmd && pwdata_in[bert_pkg::C_STOP] |-> ##2 tx_data_out == 32'h0 && !checking_out;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("stop left link or checker running");
  property p_lock_drop;
    cmd && (pwdata_in[bert_pkg::C_START] || pwdata_in[bert_pkg::C_CLR]) |-> ##1 !locked_out;
  endproperty
  a_lock_drop: assert property (p_lock_drop)
    else $error("lock kept after clear or start");
  property p_done_halts;
    $rose(done_out) |-> ##[0:1] !checking_out;
  endproperty
  a_done_halts: assert property (p_done_halts)
    else $error("checking kept after done");
  property p_preamble;
    go && cfg_reg.preamble_en && beats_reg |-> ##[1:2] tx_data_out == pre_reg;
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("preamble word not sent first");
  property p_fixed_now;
    go && fixed |-> ##[1:2] tx_data_out ==
      (cfg_reg.pattern == bert_pkg::PAT_LF ? bert_pkg::LF_WORD : bert_pkg::HF_WORD);
  endproperty
  a_fixed_now: assert property (p_fixed_now)
    else $error("fixed pattern not sent at once");
  property p_inject;
    cmd && pwdata_in[bert_pkg::C_INJ] && checking_out && fixed
      && cfg_reg.pattern == bert_pkg::PAT_HF
      |-> ##[1:3] tx_data_out == (bert_pkg::HF_WORD ^ 32'h1) ##1 tx_data_out == bert_pkg::HF_WORD;
  endproperty
  a_inject: assert property (p_inject)
    else $error("inject did not flip exactly one bit once");
  property p_bypass;
    checking_out && cfg_reg.pattern == bert_pkg::PAT_BYP && !cfg_reg.preamble_en && !cmd
      |=> !checking_out || tx_data_out == $past(user_data_in);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass word not passed through");
  c_pre: cover property (go && cfg_reg.preamble_en);
  c_done: cover property ($rose(done_out));
  c_lock: cover property ($rose(locked_out));
endmodule // bert_asserts
bind prbs_ber_test_engine bert_asserts u_asserts (.clk_in, .nrst_in, .paddr_in, .psel_in,
  .penable_in, .pwrite_in, .pwdata_in, .tx_data_out, .user_data_in, .checking_out,
  .locked_out, .done_out);
`default_nettype wire

// ---- verif/link_model.sv ----
// far-end channel model: echoes transmit words back, prompt or one word late
`timescale 1ns/1ns
`default_nettype none
module link_model (
  // clock and mode
  input wire logic clk_in,
  input wire logic slow_in,
  // line
  input wire logic [31:0] tx_data_in,
  output logic [31:0] rx_data_out,
  output logic rx_valid_out
);
  logic [31:0] dly_reg = 32'h0;
  logic [31:0] last_reg = 32'h0;
  logic [31:0] word;
  assign word = slow_in ? dly_reg : tx_data_in;
  // idle line: no valid, data inverted so stale words never look good
  assign rx_valid_out = word != 32'h0;
  assign rx_data_out = rx_valid_out ? word : ~last_reg;
  always_ff @(posedge clk_in) begin
    dly_reg <= tx_data_in;
    if (rx_valid_out) last_reg <= word;
  end
endmodule // link_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the prbs ber test engine
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] user = 32'h1;
  logic slow = 1'b0;
  logic pready, pslverr, checking, locked, done, rx_valid, err;
  logic [31:0] prdata, tx, rx, rd, n;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////
  prbs_ber_test_engine #(.RATE_WINDOW(16)) u_dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .pwdata_in(pwdata), .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
    .tx_data_out(tx), .rx_data_in(rx), .rx_valid_in(rx_valid), .user_data_in(user),
    .checking_out(checking), .locked_out(locked), .done_out(done));
  link_model u_link (.clk_in(clk_in), .slow_in(slow), .tx_data_in(tx),
    .rx_data_out(rx), .rx_valid_out(rx_valid));
  ////////////////////////////////////////////////////////////
  initial forever #50 clk_in = ~clk_in;
  // user word changes every clock
  always @(posedge clk_in) begin
    user <= user + 32'h9E3779B9;
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: run timed out", $time);
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // idle cycle between transfers
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_in);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk_word(rd & m, e);
  endtask
  task automatic run(input logic [31:0] c, input logic [31:0] m);
    apb(bert_pkg::A_CFG, 1'b1, c);
    apb(bert_pkg::A_MAXB, 1'b1, m);
    apb(bert_pkg::A_CMD, 1'b1, 32'h1);
  endtask
  // done from the previous run may still stand for a cycle
  task automatic wait_done;
    repeat (3) @(negedge clk_in);
    while (done !== 1'b1) @(negedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    chk(bert_pkg::A_CFG, 32'hFFFFFFFF, 32'h0);
    chk(bert_pkg::A_MULT, 32'hFFFFFFFF, 32'h1);
    chk(bert_pkg::A_STAT, 32'hFFFFFFFF, 32'h0);
    apb(bert_pkg::A_BITS, 1'b1, 32'h5);
    chk(bert_pkg::A_BITS, 32'hFFFFFFFF, 32'h0);
    chk(bert_pkg::A_ERRS, 32'hFFFFFFFF, 32'h0);
    apb(8'h40, 1'b0, 32'h0);
    chk_word({31'h0, err}, 32'h1);
    // every pattern except bypass through the checker, loopback for odd codes, far-end model for even codes
    for (int p = 0; p < 6; p++) begin
      slow <= p[1];
      run({25'h0, p[0], 3'h0, p[2:0]}, 32'h280);
      wait_done();
      chk(bert_pkg::A_BITS, 32'hFFFFFFFF, 32'h280);
      chk(bert_pkg::A_ERRS, 32'hFFFFFFFF, 32'h0);
      chk(bert_pkg::A_STAT, 32'h4C, 32'h4C);
    end
    apb(bert_pkg::A_CMD, 1'b1, 32'h4);
    chk(bert_pkg::A_STAT, 32'h4, 32'h0);
    chk(bert_pkg::A_BITS, 32'hFFFFFFFF, 32'h0);
    // comparator runs: one injected bit, then bypass, then word alignment
    run(32'h4B, 32'h280);
    apb(bert_pkg::A_CMD, 1'b1, 32'h8);
    wait_done();
    chk(bert_pkg::A_ERRS, 32'hFFFFFFFF, 32'h1);
    chk(bert_pkg::A_RATIO, 32'hFFFFFFFF, 32'h6666);
    run(32'h4E, 32'h140);
    wait_done();
    chk(bert_pkg::A_BITS, 32'hFFFFFFFF, 32'h140);
    chk(bert_pkg::A_ERRS, 32'hFFFFFFFF, 32'h0);
    apb(bert_pkg::A_ALIGN, 1'b1, 32'h55555555);
    run(32'hCD, 32'h140);
    wait_done();
    chk(bert_pkg::A_ERRS, 32'hFFFFFFFF, 32'hD0);
    // preamble on, then the same word with preamble off
    apb(bert_pkg::A_PRE, 1'b1, 32'h5A5A0FF0);
    apb(bert_pkg::A_BEATS, 1'b1, 32'h3);
    for (int k = 0; k < 2; k++) begin
      run(k ? 32'h05 : 32'h15, 32'h0);
      n = 32'h0;
      repeat (8) begin
        @(negedge clk_in);
        if (tx === 32'h5A5A0FF0) n = n + 32'h1;
      end
      chk_word(n, k ? 32'h0 : 32'h3);
      chk_word(tx, bert_pkg::HF_WORD);
      if (k == 1) apb(bert_pkg::A_CMD, 1'b1, 32'h8);
      apb(bert_pkg::A_CMD, 1'b1, 32'h2);
    end
    // error-rate limits: pass low, fail high, disabled
    apb(bert_pkg::A_LSTART, 1'b1, 32'h140);
    for (int k = 0; k < 3; k++) begin
      apb(bert_pkg::A_BLO, 1'b1, k == 1 ? 32'h0 : 32'h1);
      apb(bert_pkg::A_BHI, 1'b1, k == 1 ? 32'h1 : 32'hFFFFFFFF);
      run(k == 2 ? 32'h48 : 32'h68, 32'h280);
      if (k == 1) apb(bert_pkg::A_CMD, 1'b1, 32'h8);
      wait_done();
      chk(bert_pkg::A_STAT, 32'h78, k == 0 ? 32'h18 : k == 1 ? 32'h28 : 32'h48);
      apb(bert_pkg::A_BITS, 1'b0, 32'h0);
      chk_word({31'h0, rd >= 32'h140}, 32'h1);
    end
    // rate over a 16-cycle window, refclk divided by four
    apb(bert_pkg::A_MULT, 1'b1, 32'h4);
    run(32'h48, 32'h0);
    repeat (64) @(posedge clk_in);
    chk(bert_pkg::A_RATE, 32'hFFFFFFFF, 32'h200);
    chk(bert_pkg::A_REFCLK, 32'hFFFFFFFF, 32'h80);
    apb(bert_pkg::A_CMD, 1'b1, 32'h2);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
